// >>> hw/wwd_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts of the windowed watchdog
// Assumes: Included by bare name from the design and the bench
// Notes: Register index times four gives the byte address on the bus
`ifndef WWD_CFG_SVH
`define WWD_CFG_SVH

`define WWD_IDX_CTRL 3'h0
`define WWD_IDX_STATUS 3'h1
`define WWD_IDX_IRQSTAT 3'h2
`define WWD_IDX_IRQMASK 3'h3
`define WWD_IDX_KEY 3'h4

`define WWD_PERIOD_LSB 0
`define WWD_WINDOW_LSB 4
`define WWD_LOCK_BIT 7
`define WWD_BUSY_BIT 0

`define WWD_CTRL_RST 8'h00
`define WWD_STATUS_RST 8'h00
`define WWD_KEY_VALUE 8'h9d

`define WWD_EV_SYNC 0
`define WWD_EV_TIMEOUT 1
`define WWD_EV_EARLY 2
`define WWD_EV_NUM 3

`define WWD_CLK_HZ 100000000
`define WWD_OSC_HZ 1000
`define WWD_TICK_DIV (`WWD_CLK_HZ / `WWD_OSC_HZ)
`define WWD_SYNC_TICKS 2'h2
`define WWD_CODE_MAX 4'hb

`endif

// >>> hw/wwd_pkg.sv
// Purpose: Types shared by the windowed watchdog
// Assumes: Nothing beyond the constants header
// Notes: States of the watchdog-side counter
package wwd_pkg;
    typedef enum logic [1:0] {
        WWD_OFF,
        WWD_OPEN,
        WWD_CLOSED
    } wwd_state_t;
endpackage

// >>> hw/wwd_watchdog.sv
// Purpose: Windowed watchdog with control/status registers on a classic Wishbone slave
// Assumes: One clock mclk at 100 MHz; oscillator domain modelled by a tick divider
// Notes: Registers at index*4: control, status, irq status, irq mask, protection key
// Summary of operation
// R01 - Nonzero period code enables, doubling 8..8192 ticks
// R02 - In window mode period sets open interval
// R03 - Nonzero window code sets closed interval length
// R04 - Lock makes control read-only
// R05 - Lock set by one, cleared only in debug
// R06 - Nonzero period at boot end sets lock
// R07 - Control write sets sync busy flag
// R08 - Busy clears when transfer completes; read-only
// R09 - Lock writes need key; busy unprotected
// R10 - Control reset value from boot fuse
// R11 - No restart before timeout causes reset
// R12 - Restart in closed interval causes reset
// R13 - Software must not write control while busy
// R14 - Codes 0xC..0xF reserved, undefined
// R15 - Control write needs key written just before
`timescale 1ns/1ps
`include "wwd_cfg.svh"
`default_nettype none

module wwd_watchdog #(
    parameter int TICK_DIV = `WWD_TICK_DIV
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [7:0] bootFuse,
    input wire logic bootDone,
    input wire logic dbgMode,
    input wire logic restartReq,
    output logic wdtResetReq,
    output logic irq
);
    logic [2:0] regIdx;
    logic access;
    logic wrAcc;
    logic keyArmed;
    logic fuseLoaded;
    logic bootDoneQ;
    logic [7:0] ctrl;
    logic lock;
    logic sync_pending_flag;
    logic [1:0] syncTicks;
    logic [7:0] wdtCtrl;
    logic [31:0] tickCnt;
    logic tick;
    logic rstPend;
    wwd_pkg::wwd_state_t state;
    logic [13:0] cnt;
    logic [13:0] periodLen;
    logic [13:0] windowLen;
    logic [3:0] periodCode;
    logic [3:0] windowCode;
    logic ctrlWr;
    logic ctrlTry;
    logic lockWr;
    logic autoLock;
    logic syncDone;
    logic evTimeout;
    logic evEarly;
    logic [`WWD_EV_NUM-1:0] events;
    logic [`WWD_EV_NUM-1:0] irqStat;
    logic [`WWD_EV_NUM-1:0] irqMask;

    // Reserved codes fall back to the longest length
    function automatic logic [13:0] codeLen(input logic [3:0] code);
        logic [13:0] len;
        len = 14'h2000;
        if (code != 4'h0 && code <= `WWD_CODE_MAX)
        begin
            len = 14'h0008 << (code - 4'h1);
        end
        return len;
    endfunction

    // Effects happen on the edge where ack is sampled high
    assign regIdx = adr_i[4:2];
    assign access = cyc_i && stb_i && ack_o;
    assign wrAcc = access && we_i && sel_i[0];
    assign ctrlTry = wrAcc && regIdx == `WWD_IDX_CTRL;
    assign ctrlWr = ctrlTry && keyArmed && !lock && fuseLoaded; // R04 R15
    assign lockWr = wrAcc && regIdx == `WWD_IDX_STATUS && keyArmed; // R09
    assign autoLock = bootDone && !bootDoneQ && ctrl[`WWD_PERIOD_LSB +: 4] != 4'h0; // R06

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            ack_o <= 1'b0;
        end
        else
        begin
            ack_o <= cyc_i && stb_i && !ack_o;
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            dat_o <= 32'h0000_0000;
        end
        else if (cyc_i && stb_i && !ack_o)
        begin
            unique case (regIdx)
                `WWD_IDX_CTRL: dat_o <= {24'h000000, ctrl};
                `WWD_IDX_STATUS: dat_o <= {24'h000000, lock, 6'h00, sync_pending_flag};
                `WWD_IDX_IRQSTAT: dat_o <= {29'h0000_0000, irqStat};
                `WWD_IDX_IRQMASK: dat_o <= {29'h0000_0000, irqMask};
                default: dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // Key arms exactly the next write; any other write disarms it
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            keyArmed <= 1'b0;
        end
        else if (wrAcc)
        begin
            keyArmed <= regIdx == `WWD_IDX_KEY && dat_i[7:0] == `WWD_KEY_VALUE; // R15
        end
    end

    // Fuse value is caught by a clocked load after reset release
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl <= `WWD_CTRL_RST;
            fuseLoaded <= 1'b0;
        end
        else if (!fuseLoaded)
        begin
            ctrl <= bootFuse; // R10
            fuseLoaded <= 1'b1;
        end
        else if (ctrlWr)
        begin
            ctrl <= dat_i[7:0]; // R01 R03
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            lock <= 1'b0;
            bootDoneQ <= 1'b0;
        end
        else
        begin
            bootDoneQ <= bootDone;
            if (autoLock || (lockWr && dat_i[`WWD_LOCK_BIT]))
            begin
                lock <= 1'b1; // R05 R06
            end
            else if (lockWr && dbgMode)
            begin
                lock <= 1'b0; // R05
            end
        end
    end

    // Oscillator tick stands in for the slow watchdog clock
    assign tick = tickCnt == 32'(TICK_DIV - 1);

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            tickCnt <= 32'h0000_0000;
        end
        else
        begin
            tickCnt <= tick ? 32'h0000_0000 : tickCnt + 32'h0000_0001;
        end
    end

    assign syncDone = sync_pending_flag && tick && syncTicks == `WWD_SYNC_TICKS - 2'h1 && !ctrlWr;

    // Busy stays set until two ticks pass; a new write restarts the transfer
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync_pending_flag <= 1'b0;
            syncTicks <= 2'h0;
            wdtCtrl <= `WWD_CTRL_RST;
        end
        else if (ctrlWr || (!fuseLoaded))
        begin
            sync_pending_flag <= 1'b1; // R07
            syncTicks <= 2'h0;
        end
        else if (syncDone)
        begin
            sync_pending_flag <= 1'b0; // R08
            wdtCtrl <= ctrl;
        end
        else if (sync_pending_flag && tick)
        begin
            syncTicks <= syncTicks + 2'h1;
        end
    end

    // A second restart while one awaits its tick is dropped
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            rstPend <= 1'b0;
        end
        else if (restartReq)
        begin
            rstPend <= 1'b1;
        end
        else if (tick)
        begin
            rstPend <= 1'b0;
        end
    end

    assign periodCode = wdtCtrl[`WWD_PERIOD_LSB +: 4];
    assign windowCode = wdtCtrl[`WWD_WINDOW_LSB +: 4];
    assign periodLen = codeLen(periodCode);
    assign windowLen = codeLen(windowCode);
    assign evTimeout = tick && state == wwd_pkg::WWD_OPEN && !rstPend
        && periodCode != 4'h0 && cnt + 14'h1 >= periodLen;
    assign evEarly = tick && state == wwd_pkg::WWD_CLOSED && rstPend && periodCode != 4'h0;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= wwd_pkg::WWD_OFF;
            cnt <= 14'h0000;
        end
        else if (tick)
        begin
            if (periodCode == 4'h0)
            begin
                state <= wwd_pkg::WWD_OFF; // R01
                cnt <= 14'h0000;
            end
            else
            begin
                unique case (state)
                    wwd_pkg::WWD_OFF:
                    begin
                        state <= wwd_pkg::WWD_OPEN;
                        cnt <= 14'h0000;
                    end
                    wwd_pkg::WWD_OPEN:
                    begin
                        if (rstPend)
                        begin
                            // Closed interval only starts after a restart
                            state <= windowCode != 4'h0 ? wwd_pkg::WWD_CLOSED
                                : wwd_pkg::WWD_OPEN; // R02 R03 R11
                            cnt <= 14'h0000;
                        end
                        else
                        begin
                            cnt <= evTimeout ? 14'h0000 : cnt + 14'h1; // R11
                        end
                    end
                    wwd_pkg::WWD_CLOSED:
                    begin
                        if (rstPend || cnt + 14'h1 >= windowLen)
                        begin
                            state <= wwd_pkg::WWD_OPEN; // R12
                            cnt <= 14'h0000;
                        end
                        else
                        begin
                            cnt <= cnt + 14'h1;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            wdtResetReq <= 1'b0;
        end
        else
        begin
            wdtResetReq <= evTimeout || evEarly; // R11 R12
        end
    end

    assign events = {evEarly, evTimeout, syncDone};

    // Set wins over a same-cycle write-one clear
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            irqStat <= 3'h0;
            irqMask <= 3'h0;
        end
        else
        begin
            if (wrAcc && regIdx == `WWD_IDX_IRQSTAT)
            begin
                irqStat <= (irqStat & ~dat_i[`WWD_EV_NUM-1:0]) | events;
            end
            else
            begin
                irqStat <= irqStat | events;
            end
            if (wrAcc && regIdx == `WWD_IDX_IRQMASK)
            begin
                irqMask <= dat_i[`WWD_EV_NUM-1:0];
            end
        end
    end

    assign irq = |(irqStat & irqMask);

    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence s_ctrlWrite;
        ctrlWr;
    endsequence

    sequence s_transfer;
        sync_pending_flag ##1 sync_pending_flag[*1];
    endsequence

    property p_ack_single;
        ack_o |=> !ack_o;
    endproperty
    a_ack_single: assert property (p_ack_single) else $error("ack held two cycles");

    property p_sync_set;
        s_ctrlWrite |=> s_transfer;
    endproperty
    a_sync_set: assert property (p_sync_set) else $error("busy not set by write"); // R07

    property p_sync_clear;
        $fell(sync_pending_flag) |-> wdtCtrl == ctrl && $past(tick);
    endproperty
    a_sync_clear: assert property (p_sync_clear) else $error("busy cleared early"); // R08

    property p_lock_sticky;
        lock && !dbgMode |=> lock;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared outside debug"); // R05

    property p_locked_ctrl;
        lock && fuseLoaded |=> $stable(ctrl);
    endproperty
    a_locked_ctrl: assert property (p_locked_ctrl) else $error("control changed while locked"); // R04

    property p_need_key;
        ctrlTry && !keyArmed && fuseLoaded |=> $stable(ctrl);
    endproperty
    a_need_key: assert property (p_need_key) else $error("control written without key"); // R15

    property p_auto_lock;
        fuseLoaded && $rose(bootDone) && ctrl[3:0] != 4'h0 |=> lock;
    endproperty
    a_auto_lock: assert property (p_auto_lock) else $error("lock not set at boot end"); // R06

    property p_timeout;
        tick && state == wwd_pkg::WWD_OPEN && !rstPend && periodCode != 4'h0
            && cnt + 14'h1 >= periodLen |=> wdtResetReq ##1 !wdtResetReq;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout gave no reset"); // R11

    property p_early;
        tick && state == wwd_pkg::WWD_CLOSED && rstPend && periodCode != 4'h0
            |=> wdtResetReq && state == wwd_pkg::WWD_OPEN;
    endproperty
    a_early: assert property (p_early) else $error("early restart gave no reset"); // R12

    property p_off;
        tick && periodCode == 4'h0 |=> state == wwd_pkg::WWD_OFF && !wdtResetReq;
    endproperty
    a_off: assert property (p_off) else $error("disabled watchdog still running"); // R01

    property p_window;
        tick && state == wwd_pkg::WWD_OPEN && rstPend && periodCode != 4'h0
            && windowCode != 4'h0 |=> state == wwd_pkg::WWD_CLOSED && cnt == 14'h0000;
    endproperty
    a_window: assert property (p_window) else $error("restart did not close window"); // R03
endmodule

`default_nettype wire

// >>> dv/wwd_watchdog_bench.sv
// Purpose: Self-checking bench for wwd_watchdog over classic Wishbone
// Assumes: TICK_DIV of 8 keeps watchdog periods short
// Notes: Every task starts and ends just after a rising edge
`timescale 1ns/1ps
`include "wwd_cfg.svh"
`default_nettype none

module wwd_watchdog_bench;
    localparam int TD = 8;
    localparam logic [7:0] CTL = 8'h00;
    localparam logic [7:0] STA = 8'h04;
    localparam logic [7:0] IST = 8'h08;
    localparam logic [7:0] MSK = 8'h0c;
    localparam logic [7:0] KEY = 8'h10;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] datO;
    logic ack;
    logic [7:0] fuse = 8'h00;
    logic bootDone = 1'b0;
    logic dbgMode = 1'b0;
    logic restartReq = 1'b0;
    logic wdtReset;
    logic irq;
    logic [31:0] q;
    int badCount = 0;
    int cmpCount = 0;
    int cycles = 0;
    int rstCount = 0;
    int g;
    int k;

    wwd_watchdog #(.TICK_DIV(TD)) uut (
        .mclk(mclk), .nrst(nrst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(4'h1), .dat_i(dat), .dat_o(datO), .ack_o(ack),
        .bootFuse(fuse), .bootDone(bootDone), .dbgMode(dbgMode),
        .restartReq(restartReq), .wdtResetReq(wdtReset), .irq(irq)
    );

    always #5 mclk = ~mclk;

    // Hang guard sized well above the whole sequence
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (wdtReset === 1'b1)
            rstCount <= rstCount + 1;
        if (cycles == 30000)
        begin
            badCount++;
            finishTest();
        end
    end

    task automatic finishTest();
        if (badCount == 0 && cmpCount > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp)
        begin
            badCount++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Holds the request until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (ack !== 1'b1 && n < 10);
        q = datO;
        check({31'h0, ack}, 32'h1);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic kw(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, KEY, `WWD_KEY_VALUE);
        wb(1'b1, a, d);
    endtask

    task automatic waitSync();
        int n;
        n = 0;
        do
        begin
            wb(1'b0, STA, 8'h00);
            n++;
        end
        while (q[0] !== 1'b0 && n < 40);
        check({31'h0, q[0]}, 32'h0);
    endtask

    task automatic kick();
        restartReq <= 1'b1;
        @(posedge mclk);
        restartReq <= 1'b0;
        @(posedge mclk);
    endtask

    // Cycles between two successive reset pulses
    task automatic gap(output int c);
        int n;
        n = 0;
        while (wdtReset !== 1'b1 && n < 2000)
        begin
            @(posedge mclk);
            n++;
        end
        @(posedge mclk);
        c = 1;
        while (wdtReset !== 1'b1 && c < 2000)
        begin
            @(posedge mclk);
            c++;
        end
    endtask

    task automatic doReset();
        nrst <= 1'b0;
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask

    initial
    begin
        doReset();
        wb(1'b0, CTL, 8'h00);
        check(q, 32'h0);
        waitSync();
        wb(1'b0, 8'h1c, 8'h00);
        check(q, 32'h0);
        wb(1'b1, CTL, 8'h05);
        wb(1'b0, CTL, 8'h00);
        check(q, 32'h0);
        wb(1'b1, KEY, `WWD_KEY_VALUE);
        wb(1'b1, MSK, 8'h00);
        wb(1'b1, CTL, 8'h05);
        wb(1'b0, CTL, 8'h00);
        check(q, 32'h0);
        kw(CTL, 8'h01);
        wb(1'b0, STA, 8'h00);
        check(q, 32'h1);
        waitSync();
        kw(STA, 8'h01);
        wb(1'b0, STA, 8'h00);
        check(q, 32'h0);
        gap(g);
        check(g, 8 * TD);
        kw(CTL, 8'h04);
        waitSync();
        gap(g);
        check(g, 64 * TD);
        kw(CTL, 8'h01);
        waitSync();
        k = rstCount;
        repeat (12)
        begin
            kick();
            repeat (15) @(posedge mclk);
        end
        check(rstCount - k, 0);
        kw(CTL, 8'h11);
        waitSync();
        kick();
        repeat (16) @(posedge mclk);
        wb(1'b1, IST, 8'h07);
        k = rstCount;
        kick();
        repeat (16) @(posedge mclk);
        check(rstCount - k, 1);
        wb(1'b0, IST, 8'h00);
        check(q, 32'h4);
        k = rstCount;
        kick();
        repeat (80) @(posedge mclk);
        kick();
        repeat (16) @(posedge mclk);
        check(rstCount - k, 0);
        kw(CTL, 8'h00);
        waitSync();
        wb(1'b1, MSK, 8'h04);
        check({31'h0, irq}, 32'h1);
        wb(1'b1, MSK, 8'h00);
        check({31'h0, irq}, 32'h0);
        wb(1'b1, MSK, 8'h04);
        wb(1'b1, IST, 8'h04);
        check({31'h0, irq}, 32'h0);
        wb(1'b1, STA, 8'h80);
        wb(1'b0, STA, 8'h00);
        check(q, 32'h0);
        kw(STA, 8'h80);
        wb(1'b0, STA, 8'h00);
        check(q, 32'h80);
        kw(CTL, 8'h23);
        wb(1'b0, CTL, 8'h00);
        check(q, 32'h0);
        kw(STA, 8'h00);
        wb(1'b0, STA, 8'h00);
        check(q, 32'h80);
        dbgMode <= 1'b1;
        kw(STA, 8'h00);
        wb(1'b0, STA, 8'h00);
        check(q, 32'h0);
        dbgMode <= 1'b0;
        fuse <= 8'h0b;
        doReset();
        wb(1'b0, CTL, 8'h00);
        check(q, 32'hb);
        wb(1'b0, STA, 8'h00);
        check(q, 32'h1);
        waitSync();
        bootDone <= 1'b1;
        repeat (2) @(posedge mclk);
        wb(1'b0, STA, 8'h00);
        check(q, 32'h80);
        finishTest();
    end
endmodule
`default_nettype wire
